// *** bscx_pkg.sv ***
// Shared constants and types for the bit-test, call and clear execution slice.
package bscx_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned PC_W     = 15;
    localparam int unsigned ACC_W    = 8;
    localparam int unsigned FADDR_W  = 7;
    localparam int unsigned BSEL_W   = 3;
    localparam int unsigned TGT_W    = 11;
    localparam int unsigned LATCH_W  = 7;

    // ------------------------------------------------------------------
    // Register map (byte offsets, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [4:0] ACC_OFS   = 5'h00;
    localparam logic [4:0] LATCH_OFS = 5'h04;
    localparam logic [4:0] STAT_OFS  = 5'h08;
    localparam logic [4:0] GUARD_OFS = 5'h0c;
    localparam logic [4:0] PCL_OFS   = 5'h10;

    // Status word fields.
    localparam int unsigned ST_ZERO_BIT   = 0;
    localparam int unsigned ST_SLEEPN_BIT = 1;
    localparam int unsigned ST_EXPN_BIT   = 2;

    // Reset values and the clear value.
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [6:0]  LATCH_RST  = 7'h00;
    localparam logic        ZERO_RST   = 1'b0;
    localparam logic        SLEEPN_RST = 1'b1;
    localparam logic        EXPN_RST   = 1'b1;
    localparam logic [7:0]  CLR_VALUE  = 8'h00;

    // ------------------------------------------------------------------
    // Operation selectors and execution states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_SKIP_LOW  = 3'h0,
        OP_SKIP_HIGH = 3'h1,
        OP_CALL      = 3'h2,
        OP_ICALL     = 3'h3,
        OP_FZERO     = 3'h4,
        OP_AZERO     = 3'h5,
        OP_KICK      = 3'h6,
        OP_NONE      = 3'h7
    } bscx_op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_HOLD = 1'b1
    } bscx_state_t;

endpackage

// *** bscx_guard.sv ***
// Guard counter with prescaler, cleared by the guard timer kick.
`timescale 1ns/1ps
`default_nettype none

module bscx_guard #(
    parameter int unsigned CNT_W = 8,
    parameter int unsigned PRE_W = 5
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             kick_i,
    output logic [CNT_W-1:0]      count_o,
    output logic                  expire_o
);

    logic [PRE_W-1:0] pre_r;
    logic             tick;

    if (CNT_W < 1 || CNT_W > 32 || PRE_W < 1 || PRE_W > 24) begin
        $error("bscx_guard: unsupported counter widths");
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    assign tick = &pre_r;

    always_ff @(posedge clk_i) begin
        if (!rstn_i || kick_i) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i || kick_i) begin
            count_o <= '0;
        end else if (tick) begin
            count_o <= count_o + 1'b1;
        end
    end

    // Wrap of the counter is the timeout event.
    always_ff @(posedge clk_i) begin
        if (!rstn_i || kick_i) begin
            expire_o <= 1'b0;
        end else begin
            expire_o <= tick && (&count_o);
        end
    end

    guard_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        kick_i |=> (count_o == '0) && (pre_r == '0) && !expire_o)
        else $error("guard counter not cleared by kick");

endmodule
`default_nettype wire

// *** bscx_exec.sv ***
// Execution slice for bit skip, subroutine call, clear and guard kick ops.
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module bscx_exec #(
    parameter int unsigned GUARD_W = 8,
    parameter int unsigned PRE_W   = 5
) (
    input  wire logic                        clk_i,
    input  wire logic                        rstn_i,
    // Operation issue from the fetch path.
    input  wire logic                        op_valid_i,
    output logic                             op_ready_o,
    input  wire logic [2:0]                  op_sel_i,
    input  wire logic [6:0]                  op_file_i,
    input  wire logic [2:0]                  op_bit_i,
    input  wire logic [10:0]                 op_target_i,
    input  wire logic [14:0]                 pc_i,
    // Data register file.
    output logic [6:0]                       file_rd_addr_o,
    input  wire logic [7:0]                  file_rd_data_i,
    output logic                             file_wr_o,
    output logic [6:0]                       file_wr_addr_o,
    output logic [7:0]                       file_wr_data_o,
    // Return stack and program counter.
    output logic                             stack_push_o,
    output logic [14:0]                      stack_head_o,
    output logic                             pc_load_o,
    output logic [14:0]                      pc_load_val_o,
    output logic                             skip_o,
    // State seen by the rest of the core.
    output logic [7:0]                       acc_o,
    output logic                             zero_flag_o,
    output logic                             expiry_flag_n_o,
    output logic                             sleep_flag_n_o,
    output logic                             guard_expire_o,
    // Avalon-MM slave.
    input  wire logic [4:0]                  avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [31:0]                 avs_writedata_i,
    input  wire logic [3:0]                  avs_byteenable_i,
    output logic [31:0]                      avs_readdata_o,
    output logic                             avs_waitrequest_o
);

    bscx_pkg::bscx_state_t state_r;
    logic [6:0]            latch_r;
    logic [GUARD_W-1:0]    guard_cnt;
    logic                  accept;
    logic                  bit_val;
    logic                  two_cycle;
    logic                  kick;
    logic                  ack_r;
    logic                  bus_wr;
    logic                  sw_stat_wr;
    bscx_pkg::bscx_op_t    op;

    if (GUARD_W < 1 || GUARD_W > 32) begin
        $error("bscx_exec: GUARD_W must be 1 to 32");
    end

    // ------------------------------------------------------------------
    // Issue and decode
    // ------------------------------------------------------------------
    assign op         = bscx_pkg::bscx_op_t'(op_sel_i);
    assign op_ready_o = (state_r == bscx_pkg::ST_IDLE);
    assign accept     = op_valid_i && op_ready_o;
    assign kick       = accept && (op == bscx_pkg::OP_KICK);

    // The register file answers within the cycle, so the operand is
    // tested at the accept edge.
    assign file_rd_addr_o = op_file_i;
    assign bit_val        = file_rd_data_i[op_bit_i];

    always_comb begin
        unique case (op)
            bscx_pkg::OP_SKIP_LOW:  two_cycle = !bit_val;
            bscx_pkg::OP_SKIP_HIGH: two_cycle = bit_val;
            bscx_pkg::OP_CALL:      two_cycle = 1'b1;
            bscx_pkg::OP_ICALL:     two_cycle = 1'b1;
            default:                two_cycle = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Execution state
    // ------------------------------------------------------------------
    // The hold cycle is where the discarded instruction runs as a no-op,
    // or where the fetch path refills after a call.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_r <= bscx_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                bscx_pkg::ST_IDLE: begin
                    if (accept && two_cycle) begin
                        state_r <= bscx_pkg::ST_HOLD;
                    end
                end
                bscx_pkg::ST_HOLD: begin
                    state_r <= bscx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            skip_o <= 1'b0;
        end else begin
            skip_o <= accept && two_cycle &&
                      (op == bscx_pkg::OP_SKIP_LOW ||
                       op == bscx_pkg::OP_SKIP_HIGH);
        end
    end

    // ------------------------------------------------------------------
    // Return stack and program counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            stack_push_o <= 1'b0;
            stack_head_o <= '0;
        end else begin
            stack_push_o <= accept && (op == bscx_pkg::OP_CALL ||
                                       op == bscx_pkg::OP_ICALL);
            if (accept && (op == bscx_pkg::OP_CALL ||
                           op == bscx_pkg::OP_ICALL)) begin
                stack_head_o <= pc_i + 15'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pc_load_o     <= 1'b0;
            pc_load_val_o <= '0;
        end else begin
            pc_load_o <= accept && (op == bscx_pkg::OP_CALL ||
                                    op == bscx_pkg::OP_ICALL);
            if (accept && op == bscx_pkg::OP_CALL) begin
                pc_load_val_o <= {latch_r[6:3], op_target_i};
            end else if (accept && op == bscx_pkg::OP_ICALL) begin
                pc_load_val_o <= {latch_r, acc_o};
            end
        end
    end

    // ------------------------------------------------------------------
    // File clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            file_wr_o      <= 1'b0;
            file_wr_addr_o <= '0;
        end else begin
            file_wr_o <= accept && (op == bscx_pkg::OP_FZERO);
            if (accept && op == bscx_pkg::OP_FZERO) begin
                file_wr_addr_o <= op_file_i;
            end
        end
    end

    assign file_wr_data_o = bscx_pkg::CLR_VALUE;

    // ------------------------------------------------------------------
    // Accumulator, latch and flags
    // ------------------------------------------------------------------
    assign bus_wr     = avs_write_i && ack_r && avs_byteenable_i[0];
    assign sw_stat_wr = bus_wr && avs_address_i == bscx_pkg::STAT_OFS;

    // An instruction clearing the accumulator wins over a bus write.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acc_o <= bscx_pkg::ACC_RST;
        end else if (accept && op == bscx_pkg::OP_AZERO) begin
            acc_o <= bscx_pkg::CLR_VALUE;
        end else if (bus_wr && avs_address_i == bscx_pkg::ACC_OFS) begin
            acc_o <= avs_writedata_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            latch_r <= bscx_pkg::LATCH_RST;
        end else if (bus_wr && avs_address_i == bscx_pkg::LATCH_OFS) begin
            latch_r <= avs_writedata_i[6:0];
        end
    end

    // Only the clear ops and a status write touch the zero flag here; skips and calls do not.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            zero_flag_o <= bscx_pkg::ZERO_RST;
        end else if (accept && (op == bscx_pkg::OP_FZERO ||
                                op == bscx_pkg::OP_AZERO)) begin
            zero_flag_o <= 1'b1;
        end else if (sw_stat_wr) begin
            zero_flag_o <= avs_writedata_i[bscx_pkg::ST_ZERO_BIT];
        end
    end

    // A timeout in the same cycle as a kick still sets the expiry flag (expiry_flag_n_o low).
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            expiry_flag_n_o <= bscx_pkg::EXPN_RST;
        end else if (guard_expire_o) begin
            expiry_flag_n_o <= 1'b0;
        end else if (kick) begin
            expiry_flag_n_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sleep_flag_n_o <= bscx_pkg::SLEEPN_RST;
        end else if (kick) begin
            sleep_flag_n_o <= 1'b1;
        end else if (sw_stat_wr) begin
            sleep_flag_n_o <= avs_writedata_i[bscx_pkg::ST_SLEEPN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Guard counter
    // ------------------------------------------------------------------
    bscx_guard #(
        .CNT_W (GUARD_W),
        .PRE_W (PRE_W)
    ) u_guard (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .kick_i   (kick),
        .count_o  (guard_cnt),
        .expire_o (guard_expire_o)
    );

    // ------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------
    // Every access waits exactly one cycle; read data are registered so
    // they stand at the edge where waitrequest is seen low.
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_i || avs_write_i) && !ack_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack_r) begin
            unique case (avs_address_i)
                bscx_pkg::ACC_OFS:   avs_readdata_o <= {24'h000000, acc_o};
                bscx_pkg::LATCH_OFS: avs_readdata_o <= {25'h0, latch_r};
                bscx_pkg::STAT_OFS:  avs_readdata_o <= {29'h0,
                    expiry_flag_n_o, sleep_flag_n_o, zero_flag_o};
                bscx_pkg::GUARD_OFS: avs_readdata_o <= 32'(guard_cnt);
                bscx_pkg::PCL_OFS:   avs_readdata_o <= {17'h0, pc_load_val_o};
                default:             avs_readdata_o <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    skip_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_SKIP_LOW
        |=> skip_o == !$past(bit_val) && !pc_load_o)
        else $error("skip on bit low decided wrongly");

    skip_high_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_SKIP_HIGH
        |=> skip_o == $past(bit_val) && op_ready_o == !$past(bit_val))
        else $error("skip on bit high decided wrongly");

    call_push_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_CALL
        |=> stack_push_o && stack_head_o == $past(pc_i) + 15'h0001)
        else $error("call pushed wrong return address");

    call_target_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_CALL
        |=> pc_load_o &&
            pc_load_val_o == {$past(latch_r[6:3]), $past(op_target_i)})
        else $error("call loaded wrong target");

    call_len_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_CALL |=> !op_ready_o ##1 op_ready_o)
        else $error("call did not take two cycles");

    icall_push_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_ICALL
        |=> stack_push_o && pc_load_o &&
            stack_head_o == $past(pc_i) + 15'h0001)
        else $error("indirect call pushed wrong return address");

    icall_target_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_ICALL
        |=> pc_load_val_o == {$past(latch_r), $past(acc_o)})
        else $error("indirect call loaded wrong target");

    icall_len_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_ICALL |=> !op_ready_o ##1 op_ready_o)
        else $error("indirect call did not take two cycles");

    file_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_FZERO
        |=> file_wr_o && file_wr_data_o == 8'h00 && zero_flag_o &&
            file_wr_addr_o == $past(op_file_i))
        else $error("file clear wrong");

    acc_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op == bscx_pkg::OP_AZERO
        |=> acc_o == 8'h00 && zero_flag_o && !file_wr_o)
        else $error("accumulator clear wrong");

    kick_flags_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        kick && !guard_expire_o
        |=> expiry_flag_n_o && sleep_flag_n_o && $stable(zero_flag_o))
        else $error("guard kick flags wrong");

    flags_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        accept && op <= bscx_pkg::OP_ICALL && !sw_stat_wr && !guard_expire_o
        |=> $stable(zero_flag_o) && $stable(sleep_flag_n_o) &&
            $stable(expiry_flag_n_o))
        else $error("skip or call changed a flag");

endmodule
`default_nettype wire

// *** bscx_far.sv ***
// Behavioural register file and return stack on the far side of the slice.
`timescale 1ns/1ps
`default_nettype none

module bscx_far (
    input  wire logic        clk_i,
    input  wire logic [6:0]  rd_addr_i,
    output logic      [7:0]  rd_data_o,
    input  wire logic        wr_i,
    input  wire logic [6:0]  wr_addr_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        push_i,
    input  wire logic [14:0] head_i,
    output logic      [14:0] top_o,
    output logic      [4:0]  depth_o
);
    logic [7:0] mem [128];

    // Reads are combinational because the slice samples them at issue.
    assign rd_data_o = mem[rd_addr_i];
    initial top_o = 15'h0000;
    initial depth_o = 5'h00;

    always @(posedge clk_i) begin
        if (wr_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (push_i) begin
            top_o <= head_i;
            depth_o <= depth_o + 5'h01;
        end
    end
endmodule

`default_nettype wire

// *** bit_skip_call_clear_exec_tb.sv ***
// Self-checking bench for the bit-test, call and clear execution slice.
`timescale 1ns/1ps
`default_nettype none

module bit_skip_call_clear_exec_tb;
    typedef struct packed {
        logic [2:0] s; logic [6:0] f; logic [2:0] b; logic [7:0] d;
        logic [10:0] t; logic [14:0] p; logic xs; logic xp;
        logic [14:0] xh; logic [14:0] xv; logic xz;
    } bscx_row_t;
    logic clk_i = 1'b0, rstn_i = 1'b0, op_valid_i = 1'b0;
    logic [2:0] op_sel_i = 3'h7, op_bit_i = 3'h0;
    logic [6:0] op_file_i = 7'h00, file_rd_addr_o, file_wr_addr_o;
    logic [10:0] op_target_i = 11'h000;
    logic [14:0] pc_i = 15'h0000, stack_head_o, pc_load_val_o, top;
    logic [7:0] file_rd_data_i, file_wr_data_o, acc_o;
    logic [4:0] avs_address_i = 5'h00, depth;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
    logic [3:0] avs_byteenable_i = 4'h1;
    logic op_ready_o, file_wr_o, stack_push_o, pc_load_o, skip_o;
    logic zero_flag_o, expiry_flag_n_o, sleep_flag_n_o, guard_expire_o;
    logic avs_waitrequest_o;
    int fails = 0, checks_done = 0, n;
    bscx_row_t r;
    bscx_row_t rows [8] = '{
        '{3'h0,7'h05,3'h3,8'h08,11'h0,15'h0,1'b0,1'b0,15'h0,15'h0,1'b0},
        '{3'h0,7'h7f,3'h7,8'h7f,11'h0,15'h0,1'b1,1'b0,15'h0,15'h0,1'b0},
        '{3'h1,7'h00,3'h0,8'hfe,11'h0,15'h0,1'b0,1'b0,15'h0,15'h0,1'b0},
        '{3'h1,7'h40,3'h7,8'h80,11'h0,15'h0,1'b1,1'b0,15'h0,15'h0,1'b0},
        '{3'h2,7'h01,3'h0,8'h00,11'h7ff,15'h7fff,1'b0,1'b1,15'h0000,
          15'h57ff,1'b0},
        '{3'h3,7'h02,3'h0,8'h00,11'h0,15'h1234,1'b0,1'b1,15'h1235,
          15'h555a,1'b0},
        '{3'h4,7'h7f,3'h0,8'hff,11'h0,15'h0,1'b0,1'b0,15'h0,15'h0,1'b1},
        '{3'h7,7'h03,3'h0,8'h00,11'h0,15'h0,1'b0,1'b0,15'h0,15'h0,1'b1}};

    bscx_exec bscx_exec_i (.*);
    bscx_far bscx_far_i (.clk_i(clk_i), .rd_addr_i(file_rd_addr_o),
        .rd_data_o(file_rd_data_i), .wr_i(file_wr_o),
        .wr_addr_i(file_wr_addr_o), .wr_data_i(file_wr_data_o),
        .push_i(stack_push_o), .head_i(stack_head_o), .top_o(top),
        .depth_o(depth));

    always #10 clk_i = ~clk_i;

    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Holds the request until waitrequest is seen low, then releases it.
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (avs_waitrequest_o !== 1'b0 && i < 50);
        if (i >= 50) begin
            fails++;
            tally_and_finish();
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    // Offers one operation; returns one step after the accepting edge.
    task automatic op(input logic [2:0] s, input logic [6:0] f,
                      input logic [2:0] b, input logic [10:0] t,
                      input logic [14:0] p);
        int i;
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        op_sel_i <= s;
        op_file_i <= f;
        op_bit_i <= b;
        op_target_i <= t;
        pc_i <= p;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (op_ready_o !== 1'b1 && i < 50);
        if (i >= 50) begin
            fails++;
            tally_and_finish();
        end
        op_valid_i <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, 5'h08, 32'h0);
        chk("status_rst", q, 32'h6);
        bus(1'b0, 5'h04, 32'h0);
        chk("latch_rst", q, 32'h0);
        bus(1'b1, 5'h00, 32'h5a);
        bus(1'b1, 5'h04, 32'h55);
        bus(1'b0, 5'h00, 32'h0);
        chk("acc_rw", q, 32'h5a);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", q, 32'h0);
        foreach (rows[k]) begin
            r = rows[k];
            bscx_far_i.mem[r.f] = r.d;
            op(r.s, r.f, r.b, r.t, r.p);
            chk("skip", skip_o, r.xs);
            chk("ready", op_ready_o, !(r.xs | r.xp));
            chk("push", stack_push_o, r.xp);
            chk("load", pc_load_o, r.xp);
            if (r.xp) chk("head", stack_head_o, r.xh);
            if (r.xp) chk("pcval", pc_load_val_o, r.xv);
            chk("fwr", file_wr_o, r.s == 3'h4);
            chk("zero", zero_flag_o, r.xz);
        end
        @(posedge clk_i);
        #1;
        chk("fmem", bscx_far_i.mem[7'h7f], 8'h00);
        chk("depth", depth, 5'h02);
        chk("top", top, 15'h1235);
        bus(1'b0, 5'h10, 32'h0);
        chk("pcl", q, 32'h555a);
        bus(1'b1, 5'h08, 32'h6);
        op(3'h5, 7'h00, 3'h0, 11'h0, 15'h0);
        chk("acc_clr", acc_o, 8'h00);
        chk("zero_acc", zero_flag_o, 1'b1);
        bus(1'b1, 5'h08, 32'h0);
        repeat (100) @(posedge clk_i);
        op(3'h6, 7'h00, 3'h0, 11'h0, 15'h0);
        chk("sleep_n", sleep_flag_n_o, 1'b1);
        chk("expiry_n", expiry_flag_n_o, 1'b1);
        chk("zero_kick", zero_flag_o, 1'b0);
        bus(1'b0, 5'h0c, 32'h0);
        chk("guard_cnt", q, 32'h0);
        n = 0;
        while (guard_expire_o !== 1'b1 && n < 9000) begin
            @(negedge clk_i);
            n++;
        end
        chk("guard_wait", n > 8150 && n < 8200, 1'b1);
        @(posedge clk_i);
        #1;
        chk("expiry_set", expiry_flag_n_o, 1'b0);
        op(3'h6, 7'h00, 3'h0, 11'h0, 15'h0);
        chk("expiry_kick", expiry_flag_n_o, 1'b1);
        bus(1'b1, 5'h00, 32'h33);
        bus(1'b1, 5'h08, 32'h1);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        chk("acc_rst", acc_o, 8'h00);
        chk("sleep_rst", sleep_flag_n_o, 1'b1);
        chk("zero_rst", zero_flag_o, 1'b0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
